// ===== verilog/sera_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1 - busy write cycle: poll gets no acknowledge
// R2 - write cycle done: poll acknowledged low
// R3 - controller polls with start plus address word
// R4 - reads start like writes, direction bit high
// R5 - counter holds last accessed address plus one
// R6 - read: ack low, then byte MSB first
// R7 - no-ack then stop ends read, standby
// R8 - counter wraps top address to zero
// R9 - counter undefined at power-up; random read first
// R10 - random read: dummy write, two bytes, restart
// R11 - random read returns byte at loaded address
// R12 - low ack advances address, next byte out
// R13 - sequential read wraps to zero, continues
// R14 - filter pulses narrower than noise width
// R15 - power-on reset blocks spurious programming
// R16 - controller holds lines steady during power switching
// R17 - address word: type, select, direction; mismatch standby
// R18 - two address bytes, each acknowledged low
// R19 - during write cycle ignore all but polls
// R20 - no ack and no stop: line released
// R21 - thirteen-bit counter wraps naturally
// R22 - sample on rising clock, change while low
module sera_dev
  import sera_pkg::*;
#(
  parameter int WR_CYC = WR_CYCLE_CYC
) (
  // user-side clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // link-side sampling clock
  input  wire logic       link_clk,
  // hard-wired select straps
  input  wire logic [2:0] chip_select_pins,
  // write cycle status in the user domain
  output logic            write_busy,
  // two-wire link
  sera_link_if.dev        link
);
  localparam int          NPIN     = 5;
  localparam int          NCW      = 4;
  localparam int          BW       = $clog2(WR_CYC + 1);
  localparam int          PW       = $clog2(POR_CYC + 1);
  localparam logic [NPIN-1:0] PIN_IDLE = 5'h03;

  logic [NPIN-1:0]        pin_raw;
  logic [NPIN-1:0]        pin_f;
  logic                   scl;
  logic                   sda;
  logic                   scl_q;
  logic                   sda_q;
  logic                   rise;
  logic                   fall;
  logic                   start_ev;
  logic                   stop_ev;
  logic [PW-1:0]          por_cnt;
  logic                   por_ok;
  sera_dstate_t           state;
  sera_byte_t             what;
  logic [2:0]             bits;
  logic [7:0]             rx_sh;
  logic [7:0]             rx_byte;
  logic [7:0]             tx_sh;
  logic [7:0]             mem [2**ADDR_BITS];
  logic [7:0]             rd_byte;
  logic [ADDR_BITS-1:0]   ptr;
  logic [ADDR_BITS-9:0]   addr_hi;
  logic                   reading;
  logic                   ack_en;
  logic                   mack;
  logic                   wrote;
  logic                   sda_low;
  logic                   load_byte;
  logic                   mem_we;
  logic                   busy;
  logic [BW-1:0]          busy_cnt;
  logic                   busy_m;

  // next address inside the same page during writes
  function automatic logic [ADDR_BITS-1:0] page_next(input logic [ADDR_BITS-1:0] a);
    page_next = {a[ADDR_BITS-1:PAGE_BITS], a[PAGE_BITS-1:0] + PAGE_BITS'(1)};
  endfunction

  // ==========================================================
  // input conditioning: three flops, last two must agree, width filter
  assign pin_raw = {chip_select_pins, link.sda, link.scl};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_filt
      logic           s1;
      logic           s2;
      logic           s3;
      logic           f;
      logic [NCW-1:0] stab;
      // a change is taken only once it has held for the noise width
      always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
          s1   <= PIN_IDLE[gi];
          s2   <= PIN_IDLE[gi];
          s3   <= PIN_IDLE[gi];
          f    <= PIN_IDLE[gi];
          stab <= '0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 != s3 || s3 == f) begin
            stab <= '0;
          end else if (stab >= NCW'(NOISE_CYC - 1)) begin
            f    <= s3; // R14
            stab <= '0;
          end else begin
            stab <= stab + NCW'(1);
          end
        end
      end
      assign pin_f[gi] = f;
    end
  endgenerate

  assign scl = pin_f[0];
  assign sda = pin_f[1];

  // bus events from the filtered lines
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign rise     = scl && !scl_q; // R22
  assign fall     = !scl && scl_q; // R22
  assign start_ev = por_ok && scl && scl_q && sda_q && !sda;
  assign stop_ev  = por_ok && scl && scl_q && !sda_q && sda;

  // power-on guard: arm only after a quiet idle bus for a while
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt <= '0;
      por_ok  <= 1'b0;
    end else if (!por_ok) begin
      if (!(scl && sda)) begin
        por_cnt <= '0; // R15
      end else if (por_cnt == PW'(POR_CYC)) begin
        por_ok <= 1'b1; // R15
      end else begin
        por_cnt <= por_cnt + PW'(1);
      end
    end
  end

  // ==========================================================
  // byte array
  assign rx_byte = {rx_sh[6:0], sda};
  assign rd_byte = mem[ptr];
  assign mem_we  = rise && (state == D_RX) && (bits == 3'h7) && (what == BYTE_DATA);
  assign load_byte = fall && ((state == D_ACK && ack_en && reading) ||
                              (state == D_MACK && !mack));

  // array contents are undefined until written
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[ptr] <= rx_byte;
    end
  end

  // ==========================================================
  // protocol engine
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      state   <= D_IDLE;
      what    <= BYTE_DEV;
      bits    <= 3'h0;
      rx_sh   <= 8'h00;
      tx_sh   <= 8'h00;
      ptr     <= '0; // R9
      addr_hi <= '0;
      reading <= 1'b0;
      ack_en  <= 1'b0;
      mack    <= 1'b1;
      wrote   <= 1'b0;
      sda_low <= 1'b0;
    end else if (stop_ev) begin
      state   <= D_IDLE; // R7
      sda_low <= 1'b0;
      wrote   <= 1'b0;
    end else if (start_ev) begin
      state   <= D_RX; // R4
      what    <= BYTE_DEV;
      bits    <= 3'h0;
      reading <= 1'b0;
      sda_low <= 1'b0;
    end else if (load_byte) begin
      tx_sh   <= rd_byte; // R6 R11
      sda_low <= !rd_byte[7]; // R6
      ptr     <= ptr + ADDR_BITS'(1); // R5 R8 R12 R13 R21
      bits    <= 3'h0;
      state   <= D_TX;
    end else begin
      case (state)
        D_RX: if (rise) begin
          rx_sh <= rx_byte; // R22
          bits  <= bits + 3'h1;
          if (bits == 3'h7) begin
            state  <= D_ACKSET;
            ack_en <= 1'b1;
            case (what)
              BYTE_DEV: begin
                if (rx_byte[7:4] != DEV_TYPE_CODE || rx_byte[3:1] != pin_f[4:2]) begin
                  state <= D_HOLD; // R17
                end
                ack_en  <= !busy; // R1 R2 R19
                reading <= rx_byte[0]; // R4
                what    <= BYTE_AHI;
              end
              BYTE_AHI: begin
                addr_hi <= rx_byte[ADDR_BITS-9:0]; // R18
                what    <= BYTE_ALO;
              end
              BYTE_ALO: begin
                ptr  <= {addr_hi, rx_byte}; // R10
                what <= BYTE_DATA;
              end
              default: begin
                ptr   <= page_next(ptr); // R5
                wrote <= 1'b1;
              end
            endcase
          end
        end
        D_ACKSET: if (fall) begin
          sda_low <= ack_en; // R6 R18
          state   <= D_ACK;
        end
        D_ACK: if (fall) begin
          sda_low <= 1'b0;
          bits    <= 3'h0;
          state   <= ack_en ? D_RX : D_HOLD; // R1 R19
        end
        D_TX: if (fall) begin
          if (bits == 3'h7) begin
            sda_low <= 1'b0;
            state   <= D_MACK;
          end else begin
            bits    <= bits + 3'h1;
            tx_sh   <= {tx_sh[6:0], 1'b0};
            sda_low <= !tx_sh[6]; // R6 R22
          end
        end
        D_MACK: if (rise) begin
          mack <= sda;
        end else if (fall) begin
          sda_low <= 1'b0;
          state   <= D_HOLD; // R20
        end
        D_HOLD: sda_low <= 1'b0; // R20
        default: state <= D_IDLE;
      endcase
    end
  end

  // self-timed write cycle launched by the stop after data
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      busy     <= 1'b0;
      busy_cnt <= '0;
    end else if (stop_ev && wrote && !busy) begin
      busy     <= 1'b1; // R19
      busy_cnt <= BW'(WR_CYC - 1);
    end else if (busy) begin
      if (busy_cnt == '0) begin
        busy <= 1'b0; // R2
      end else begin
        busy_cnt <= busy_cnt - BW'(1);
      end
    end
  end

  // ==========================================================
  // pins and status crossing
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe  = sda_low;

  // busy level into the user domain through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_m     <= 1'b0;
      write_busy <= 1'b0;
    end else begin
      busy_m     <= busy;
      write_busy <= busy_m;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sera_pkg.sv
`default_nettype none
package sera_pkg;
  // ==========================================================
  // array geometry
  localparam int ADDR_BITS = 13;
  localparam int PAGE_BITS = 5;
  // device type code compared against the top nibble (arbitrary value)
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

  // ==========================================================
  // clocks and times
  localparam int CLK_PERIOD_NS  = 40;
  localparam int LINK_PERIOD_NS = 80;
  localparam int SCL_PERIOD_NS  = 2500;
  localparam int NOISE_NS       = 50;
  localparam int POR_NS         = 1000;
  localparam int WR_CYCLE_NS    = 5000000;
  // quarter of a serial clock period in controller cycles, rounded up
  localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  // least pulse width to pass the input filter, rounded up
  localparam int NOISE_CYC = (NOISE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  // quiet idle time after reset before the link is armed, rounded up
  localparam int POR_CYC = (POR_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  // self-timed write cycle in link cycles, rounded down
  localparam int WR_CYCLE_CYC = WR_CYCLE_NS / LINK_PERIOD_NS;

  // ==========================================================
  // controller commands
  typedef enum logic [1:0] {
    CMD_CUR   = 2'h0,
    CMD_RAND  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_POLL  = 2'h3
  } sera_cmd_t;

  // which byte is being moved
  typedef enum logic [1:0] {
    BYTE_DEV  = 2'h0,
    BYTE_AHI  = 2'h1,
    BYTE_ALO  = 2'h2,
    BYTE_DATA = 2'h3
  } sera_byte_t;

  // device states
  typedef enum logic [6:0] {
    D_IDLE   = 7'h01,
    D_RX     = 7'h02,
    D_ACKSET = 7'h04,
    D_ACK    = 7'h08,
    D_TX     = 7'h10,
    D_MACK   = 7'h20,
    D_HOLD   = 7'h40
  } sera_dstate_t;

  // controller states
  typedef enum logic [4:0] {
    C_IDLE  = 5'h01,
    C_START = 5'h02,
    C_TX    = 5'h04,
    C_RX    = 5'h08,
    C_STOP  = 5'h10
  } sera_cstate_t;
endpackage
`default_nettype wire

// ===== verilog/sera_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sera_link_if;
  // ==========================================================
  // serial clock, driven by the controller only
  logic scl;
  // open-drain data line: each end pulls low while its enable is high
  logic ctl_sda_out;
  logic ctl_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // wired-and resolution with pull-up
  assign sda = !((ctl_sda_oe && !ctl_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport ctl (output scl, output ctl_sda_out, output ctl_sda_oe, input sda);
  modport dev (input scl, output dev_sda_out, output dev_sda_oe, input sda);
endinterface
`default_nettype wire

// ===== verilog/sera_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module sera_ctl
  import sera_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // command request
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire sera_cmd_t            cmd_kind,
  input  wire logic [2:0]           cmd_sel,
  input  wire logic [ADDR_BITS-1:0] cmd_addr,
  input  wire logic [7:0]           cmd_wdata,
  input  wire logic [7:0]           cmd_len,
  // read data and completion
  output logic                      rd_valid,
  output logic [7:0]                rd_data,
  output logic                      done,
  output logic                      done_nack,
  // two-wire link
  sera_link_if.ctl                  link
);
  localparam int QW = $clog2(QUARTER + 1);

  sera_cstate_t          state;
  sera_cmd_t             kind;
  sera_byte_t            txsel;
  logic [2:0]            sel;
  logic [ADDR_BITS-1:0]  addr;
  logic [7:0]            wdata;
  logic [7:0]            left;
  logic [7:0]            sh;
  logic [3:0]            bits;
  logic [1:0]            q;
  logic [QW-1:0]         div;
  logic                  tick;
  logic                  second;
  logic                  rw;
  logic                  ack_bad;
  logic                  scl_hi;
  logic                  sda_low;
  logic                  sda_s1;
  logic                  sda_s2;
  logic                  sda_s3;
  logic                  sda_in;

  // ==========================================================
  // pins: open-drain data, clock driven high/low
  assign link.scl         = scl_hi;
  assign link.ctl_sda_out = 1'b0;
  assign link.ctl_sda_oe  = sda_low;
  assign cmd_ready        = (state == C_IDLE);

  // data line sampled through three flops, taken when the last two agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      sda_in <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      if (sda_s2 == sda_s3) begin
        sda_in <= sda_s3;
      end
    end
  end

  // quarter-period divider making the serial clock
  assign tick = (div == QW'(QUARTER - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div <= '0;
    end else if (state == C_IDLE || tick) begin
      div <= '0;
    end else begin
      div <= div + QW'(1);
    end
  end

  // ==========================================================
  // transfer sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= C_IDLE;
      kind      <= CMD_CUR;
      txsel     <= BYTE_DEV;
      sel       <= 3'h0;
      addr      <= '0;
      wdata     <= 8'h00;
      left      <= 8'h00;
      sh        <= 8'h00;
      bits      <= 4'h0;
      q         <= 2'h0;
      second    <= 1'b0;
      rw        <= 1'b0;
      ack_bad   <= 1'b0;
      scl_hi    <= 1'b1; // R16
      sda_low   <= 1'b0; // R16
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
      done      <= 1'b0;
      done_nack <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (tick) begin
        q <= q + 2'h1;
      end
      case (state)
        C_IDLE: begin
          q <= 2'h0;
          if (cmd_valid) begin
            kind      <= cmd_kind;
            sel       <= cmd_sel;
            addr      <= cmd_addr;
            wdata     <= cmd_wdata;
            left      <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            second    <= 1'b0;
            done_nack <= 1'b0;
            state     <= C_START;
          end
        end
        C_START: if (tick) begin
          case (q)
            2'h0: begin
              scl_hi  <= 1'b0;
              sda_low <= 1'b0;
            end
            2'h1: scl_hi <= 1'b1;
            2'h2: sda_low <= 1'b1;
            default: begin
              scl_hi <= 1'b0;
              rw     <= (kind == CMD_CUR) || second; // R4
              sh     <= {DEV_TYPE_CODE, sel, (kind == CMD_CUR) || second}; // R17
              txsel  <= BYTE_DEV;
              bits   <= 4'h0;
              state  <= C_TX;
            end
          endcase
        end
        C_TX: if (tick) begin
          case (q)
            2'h0: begin
              scl_hi  <= 1'b0;
              sda_low <= (bits < 4'h8) ? !sh[7] : 1'b0;
            end
            2'h1: scl_hi <= 1'b1;
            2'h2: if (bits == 4'h8) begin
              ack_bad <= sda_in;
            end
            default: begin
              scl_hi <= 1'b0;
              bits   <= bits + 4'h1;
              sh     <= {sh[6:0], 1'b0};
              if (bits == 4'h8) begin
                bits <= 4'h0;
                if (ack_bad) begin
                  done_nack <= 1'b1;
                  state     <= C_STOP;
                end else begin
                  case (txsel)
                    BYTE_DEV: begin
                      if (rw) begin
                        state <= C_RX;
                      end else if (kind == CMD_POLL) begin
                        state <= C_STOP; // R3
                      end else begin
                        txsel <= BYTE_AHI; // R18
                        sh    <= 8'((addr >> 8));
                      end
                    end
                    BYTE_AHI: begin
                      txsel <= BYTE_ALO;
                      sh    <= addr[7:0];
                    end
                    BYTE_ALO: begin
                      if (kind == CMD_WRITE) begin
                        txsel <= BYTE_DATA;
                        sh    <= wdata;
                      end else begin
                        second <= 1'b1; // R10
                        state  <= C_START;
                      end
                    end
                    default: state <= C_STOP;
                  endcase
                end
              end
            end
          endcase
        end
        C_RX: if (tick) begin
          case (q)
            2'h0: begin
              scl_hi  <= 1'b0;
              sda_low <= (bits == 4'h8) ? (left != 8'h01) : 1'b0; // R12
            end
            2'h1: scl_hi <= 1'b1;
            2'h2: if (bits < 4'h8) begin
              sh <= {sh[6:0], sda_in};
            end
            default: begin
              scl_hi <= 1'b0;
              bits   <= bits + 4'h1;
              if (bits == 4'h7) begin
                rd_valid <= 1'b1;
                rd_data  <= sh;
              end
              if (bits == 4'h8) begin
                bits <= 4'h0;
                left <= left - 8'h01;
                if (left == 8'h01) begin
                  state <= C_STOP; // R7
                end
              end
            end
          endcase
        end
        C_STOP: if (tick) begin
          case (q)
            2'h0: begin
              scl_hi  <= 1'b0;
              sda_low <= 1'b1;
            end
            2'h1: scl_hi <= 1'b1;
            2'h2: sda_low <= 1'b0;
            default: begin
              done  <= 1'b1;
              state <= C_IDLE;
            end
          endcase
        end
        default: state <= C_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== bench/sera_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sera_assertions
  import sera_pkg::*;
#(
  parameter logic [2:0] SEL = 3'h0
) (
  // clock and reset
  input wire logic link_clk,
  input wire logic rstn,
  // link lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  // ==========================================================
  // frame tracking
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bcnt;
  logic [2:0] nby;
  logic [8:0] sh;
  logic [7:0] wd;
  logic       wack;
  logic       rel;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rstn);

  // bit and byte position since the last start or stop
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bcnt  <= 4'h0;
      nby   <= 3'h0;
      sh    <= 9'h000;
      wd    <= 8'h00;
      wack  <= 1'b0;
      rel   <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda != sda_q) begin
        bcnt <= 4'h0;
        nby  <= 3'h0;
        wd   <= 8'h00;
        wack <= 1'b0;
        rel  <= 1'b0;
      end else if (scl && !scl_q) begin
        sh   <= {sh[7:0], sda};
        bcnt <= (bcnt == 4'h8) ? 4'h0 : bcnt + 4'h1;
        if (bcnt == 4'h8 && nby != 3'h7) nby <= nby + 3'h1;
        if (bcnt == 4'h8 && nby == 3'h0) wd <= sh[7:0];
        if (bcnt == 4'h8 && nby == 3'h0) wack <= !sda;
        if (bcnt == 4'h8 && nby != 3'h0 && wd[0] && sda) rel <= 1'b1;  // controller left ack high
      end
    end
  end

  // ==========================================================
  // device side of the link
  property p_change_scl_low;
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 3);
  endproperty
  a_change_scl_low: assert property (p_change_scl_low) else $error("device data moved near a high clock");

  property p_addr_quiet;
    (nby == 3'h0 && bcnt != 4'h0 && scl && scl_q) |-> !dev_sda_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address word");

  property p_mismatch_nack;
    (nby == 3'h1 && bcnt == 4'h0 && scl && scl_q && sh[8:2] != {DEV_TYPE_CODE, SEL}) |-> !dev_sda_oe;
  endproperty
  a_mismatch_nack: assert property (p_mismatch_nack) else $error("foreign address word acknowledged");

  property p_read_ack;
    (nby == 3'h1 && bcnt == 4'h0 && scl && scl_q && sh[8:1] == {DEV_TYPE_CODE, SEL, 1'b1}) |-> dev_sda_oe;
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read address word not acknowledged");

  property p_addr_byte_ack;
    (bcnt == 4'h0 && (nby == 3'h2 || nby == 3'h3) && wack && !wd[0] && scl && scl_q) |-> dev_sda_oe;
  endproperty
  a_addr_byte_ack: assert property (p_addr_byte_ack) else $error("memory address byte not acknowledged");

  property p_nack_release;
    $rose(rel) |-> !dev_sda_oe [*8];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("device drove after no acknowledge");

  property p_read_ack_slot;
    (bcnt == 4'h0 && nby >= 3'h2 && wd[0] && wack && scl && scl_q) |-> !dev_sda_oe;
  endproperty
  a_read_ack_slot: assert property (p_read_ack_slot) else $error("device held the read acknowledge slot");

  property p_idle_release;
    (nby == 3'h0 && bcnt == 4'h0 && scl && scl_q) |-> !dev_sda_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("device drove while in standby");
endmodule
`default_nettype wire

// ===== bench/sera_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sera_tb_top
  import sera_pkg::*;
;
  // ==========================================================
  // settings and signals
  localparam int         WR_SIM = 1500;
  localparam logic [2:0] SEL    = 3'h5;
  logic                 clk;
  logic                 link_clk;
  logic                 rstn;
  logic                 cmd_valid;
  logic                 cmd_ready;
  sera_cmd_t            cmd_kind;
  logic [2:0]           cmd_sel;
  logic [ADDR_BITS-1:0] cmd_addr;
  logic [7:0]           cmd_wdata;
  logic [7:0]           cmd_len;
  logic                 rd_valid;
  logic [7:0]           rd_data;
  logic                 done;
  logic                 done_nack;
  logic                 write_busy;
  logic [7:0]           got [$];
  int                   num_errors;
  int                   n_tests;

  sera_link_if link_bus ();

  // both ends joined on one link
  sera_ctl u_sera_ctl (
    .clk       (clk),
    .rstn      (rstn),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_kind  (cmd_kind),
    .cmd_sel   (cmd_sel),
    .cmd_addr  (cmd_addr),
    .cmd_wdata (cmd_wdata),
    .cmd_len   (cmd_len),
    .rd_valid  (rd_valid),
    .rd_data   (rd_data),
    .done      (done),
    .done_nack (done_nack),
    .link      (link_bus)
  );
  sera_dev #(.WR_CYC(WR_SIM)) u_sera_dev (
    .clk              (clk),
    .rstn             (rstn),
    .link_clk         (link_clk),
    .chip_select_pins (SEL),
    .write_busy       (write_busy),
    .link             (link_bus)
  );
  sera_assertions #(.SEL(SEL)) u_sera_assertions (
    .link_clk   (link_clk),
    .rstn       (rstn),
    .scl        (link_bus.scl),
    .sda        (link_bus.sda),
    .dev_sda_oe (link_bus.dev_sda_oe)
  );

  // ==========================================================
  // clocks, unrelated in phase
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  // ==========================================================
  // compare and report tasks
  task automatic chk1(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one command from request to done, read bytes collected
  task automatic run_cmd(input sera_cmd_t k, input logic [2:0] s, input logic [12:0] a,
                         input logic [7:0] w, input logic [7:0] n);
    int t;
    @(negedge clk);
    cmd_kind  = k;
    cmd_sel   = s;
    cmd_addr  = a;
    cmd_wdata = w;
    cmd_len   = n;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk1("cmd_ready", 1'b0, cmd_ready);
    got.delete();
    t = 0;
    while (done !== 1'b1 && t < 20000) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
      t++;
    end
    if (t >= 20000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // read bytes against the expected list
  task automatic chk_read(input logic [7:0] e [$]);
    chk1("read_nack", 1'b0, done_nack);
    chk8("read_count", 8'(e.size()), 8'(got.size()));
    foreach (e[i]) chk8("rd_data", e[i], (i < got.size()) ? got[i] : 8'hxx);
  endtask

  // bounded polling until the write cycle ends
  task automatic poll_free();
    for (int i = 0; i < 10; i++) begin
      run_cmd(CMD_POLL, SEL, 13'h0000, 8'h00, 8'h01);
      if (done_nack === 1'b0) break;
    end
    chk1("poll_ack", 1'b0, done_nack);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    num_errors = 0;
    n_tests    = 0;
    rstn       = 1'b0;
    cmd_valid  = 1'b0;
    cmd_kind   = CMD_CUR;
    cmd_sel    = SEL;
    cmd_addr   = 13'h0000;
    cmd_wdata  = 8'h00;
    cmd_len    = 8'h01;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    // device needs a quiet bus before the first frame
    repeat (60) @(negedge clk);
    run_cmd(CMD_WRITE, SEL, 13'h1ffe, 8'h5a, 8'h01);
    chk1("write_nack", 1'b0, done_nack);
    run_cmd(CMD_RAND, SEL, 13'h1ffe, 8'h00, 8'h01);
    chk1("busy_nack", 1'b1, done_nack);
    chk1("write_busy", 1'b1, write_busy);
    run_cmd(CMD_POLL, SEL, 13'h0000, 8'h00, 8'h01);
    chk1("poll_nack", 1'b1, done_nack);
    poll_free();
    chk1("write_busy", 1'b0, write_busy);
    run_cmd(CMD_WRITE, SEL, 13'h1fff, 8'ha5, 8'h01);
    poll_free();
    run_cmd(CMD_WRITE, SEL, 13'h0000, 8'h3c, 8'h01);
    poll_free();
    run_cmd(CMD_RAND, SEL, 13'h1ffe, 8'h00, 8'h01);
    chk_read('{8'h5a});
    run_cmd(CMD_RAND, SEL ^ 3'h1, 13'h0000, 8'h00, 8'h01);
    chk1("sel_nack", 1'b1, done_nack);
    run_cmd(CMD_CUR, SEL, 13'h0000, 8'h00, 8'h01);
    chk_read('{8'ha5});
    run_cmd(CMD_CUR, SEL, 13'h0000, 8'h00, 8'h01);
    chk_read('{8'h3c});
    run_cmd(CMD_RAND, SEL, 13'h1ffe, 8'h00, 8'h03);
    chk_read('{8'h5a, 8'ha5, 8'h3c});
    tally_and_finish();
  end
endmodule
`default_nettype wire
